//--- design/cfo_pkg.sv
// package: register map, field layout and constants for the capture/frequency-output counter array
package cfo_pkg;
    localparam int CFO_NMOD = 4;
    localparam logic [7:0] CFO_ADDR_CTRL = 8'h00;
    localparam logic [7:0] CFO_ADDR_MODE = 8'h04;
    localparam logic [7:0] CFO_ADDR_CNT = 8'h08;
    localparam logic [7:0] CFO_ADDR_PIN = 8'h0c;
    localparam logic [7:0] CFO_ADDR_MMODE0 = 8'h10;
    localparam logic [7:0] CFO_ADDR_CAP0 = 8'h20;
    localparam logic [7:0] CFO_ADDR_IMASK = 8'h30;
    localparam logic [7:0] CFO_MOD_STRIDE = 8'h04;
    // module mode bits
    localparam int CFO_B_FLAGIE = 0;
    localparam int CFO_B_PWM = 1;
    localparam int CFO_B_TOG = 2;
    localparam int CFO_B_MAT = 3;
    localparam int CFO_B_FALL = 4;
    localparam int CFO_B_RISE = 5;
    localparam int CFO_B_COMP = 6;
    localparam int CFO_B_PWM16 = 7;
    // array mode fields
    localparam int CFO_CPS_LSB = 1;
    localparam int CFO_LEN_LSB = 8;
    // control register run bit, clock source codes, divider terminal counts, bus responses, zero-offset step
    localparam int CFO_RUN_BIT = 6;
    localparam logic [2:0] CFO_CPS_SYS12 = 3'h0;
    localparam logic [2:0] CFO_CPS_SYS4 = 3'h1;
    localparam logic [2:0] CFO_CPS_EXT = 3'h2;
    localparam logic [2:0] CFO_CPS_SYS = 3'h4;
    localparam logic [3:0] CFO_DIV12 = 4'hb;
    localparam logic [3:0] CFO_DIV4 = 4'h3;
    localparam logic [1:0] CFO_RESP_OKAY = 2'h0;
    localparam logic [1:0] CFO_RESP_SLVERR = 2'h2;
    localparam logic [8:0] CFO_OFS_ZERO = 9'h100;
endpackage

//--- design/cfo_module.sv
// one capture/compare module: edge capture, frequency output with 16-bit match, and pwm
`timescale 1ns/10ps
`default_nettype none
module cfo_module
    import cfo_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic tick, // one array clock
    input wire logic [15:0] count, // shared counter
    input wire logic [7:0] mode, // module mode byte
    input wire logic [1:0] len_sel, // shared pwm length
    input wire logic pin_in, // synchronous pin level
    input wire logic wr_low, // software writes low byte
    input wire logic wr_high, // software writes high byte
    input wire logic [15:0] wdata, // write lanes 0 and 1
    output logic [15:0] cap, // capture/compare pair
    output logic pin_out, // drive level
    output logic event_hit // one-cycle flag set pulse
);
    typedef struct packed {
        logic [15:0] cap;
        logic prev;
        logic out;
        logic hit;
    } cfo_mst_s;
    cfo_mst_s st_reg, st_next;
    logic freq_mode, rise, fall, pwm_mode;
    logic [15:0] lmask;
    logic [8:0] ofs;
    always_comb
    begin
        freq_mode = mode[CFO_B_COMP] & mode[CFO_B_TOG] & mode[CFO_B_PWM];
        pwm_mode = mode[CFO_B_COMP] & mode[CFO_B_PWM] & ~mode[CFO_B_TOG];
        rise = mode[CFO_B_RISE] & pin_in & ~st_reg.prev;
        fall = mode[CFO_B_FALL] & ~pin_in & st_reg.prev;
        // one length for every pwm module not in 16-bit mode: len_sel is shared, not per module
        lmask = 16'h00ff;
        case (len_sel)
            2'h1: lmask = 16'h01ff;
            2'h2: lmask = 16'h03ff;
            2'h3: lmask = 16'h07ff;
            default: lmask = 16'h00ff;
        endcase
        ofs = (st_reg.cap[15:8] == 8'h00) ? CFO_OFS_ZERO : {1'b0, st_reg.cap[15:8]};
        st_next = st_reg;
        st_next.prev = pin_in;
        st_next.hit = 1'b0;
        // each byte comes from its own lane so a full-word write sets both halves
        if (wr_low)
            st_next.cap[7:0] = wdata[7:0];
        if (wr_high)
            st_next.cap[15:8] = wdata[15:8];
        if (rise | fall)
        begin
            st_next.cap = count;
            st_next.hit = 1'b1;
        end
        if (tick & freq_mode & (st_reg.cap[7:0] == count[7:0]))
        begin
            st_next.out = ~st_reg.out;
            st_next.cap[7:0] = 8'((9'(st_reg.cap[7:0]) + ofs));
        end
        if (tick & freq_mode & mode[CFO_B_MAT] & (st_reg.cap == count))
            st_next.hit = 1'b1;
        if (tick & pwm_mode)
        begin
            if (mode[CFO_B_PWM16])
                st_next.out = (count < st_reg.cap);
            else
                st_next.out = ((count & lmask) < (st_reg.cap & lmask));
        end
        if (~aresetn)
            st_next = '0;
    end
    always_ff @(posedge aclk)
        st_reg <= st_next;
    assign cap = st_reg.cap;
    assign pin_out = st_reg.out;
    assign event_hit = st_reg.hit;
    // capture: value taken from counter on an enabled edge
    cap_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode[CFO_B_RISE] && pin_in && !st_reg.prev) |=> (st_reg.cap == $past(count) && st_reg.hit))
        else $error("capture missed rising edge");
    freq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!mode[CFO_B_TOG] || !mode[CFO_B_COMP]) && $past(aresetn) && !pwm_mode |=> $stable(st_reg.out))
        else $error("output toggled outside frequency mode");
endmodule
`default_nettype wire

//--- design/cfo_top.sv
// counter array top: axi4-lite slave, shared counter, clock select, flags, irq
`timescale 1ns/10ps
`default_nettype none
module cfo_top
    import cfo_pkg::*;
(
    input wire logic aclk, // system clock 125 MHz
    input wire logic aresetn, // sync reset, active low
    input wire logic [7:0] s_awaddr, // write address
    input wire logic s_awvalid, // write address valid
    output logic s_awready, // write address ready
    input wire logic [31:0] s_wdata, // write data
    input wire logic [3:0] s_wstrb, // byte strobes
    input wire logic s_wvalid, // write data valid
    output logic s_wready, // write data ready
    output logic [1:0] s_bresp, // write response
    output logic s_bvalid, // write response valid
    input wire logic s_bready, // write response ready
    input wire logic [7:0] s_araddr, // read address
    input wire logic s_arvalid, // read address valid
    output logic s_arready, // read address ready
    output logic [31:0] s_rdata, // read data
    output logic [1:0] s_rresp, // read response
    output logic s_rvalid, // read data valid
    input wire logic s_rready, // read data ready
    input wire logic ext_clk_in, // external count source, synchronous
    input wire logic [CFO_NMOD-1:0] pin_in, // module_io_pin input levels
    output logic [CFO_NMOD-1:0] pin_out, // module_io_pin drive levels
    output logic [CFO_NMOD-1:0] pin_oe, // module_io_pin drive enables
    output logic irq // level interrupt
);
    typedef struct packed {
        logic [15:0] count;
        logic [3:0] div;
        logic ext_prev;
        logic run;
        logic [CFO_NMOD-1:0] flags;
        logic [CFO_NMOD-1:0] imask;
        logic [2:0] cps;
        logic [1:0] len;
        logic [CFO_NMOD-1:0][7:0] mmode;
        logic [CFO_NMOD-1:0] oe;
        logic [CFO_NMOD-1:0] pout;
        logic awok;
        logic [7:0] awaddr;
        logic wok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
    } cfo_top_s;
    cfo_top_s st_reg, st_next;
    logic tick, do_wr;
    logic [CFO_NMOD-1:0] hit, wr_lo, wr_hi;
    logic [CFO_NMOD-1:0][15:0] cap;
    logic [CFO_NMOD-1:0] mout;
    // array clock pulse from the selected source: system clock divided by 12 or 4, undivided, or external rising edge
    always_comb
    begin
        case (st_reg.cps)
            CFO_CPS_SYS12: tick = st_reg.run & (st_reg.div == CFO_DIV12);
            CFO_CPS_SYS4: tick = st_reg.run & (st_reg.div == CFO_DIV4);
            CFO_CPS_EXT: tick = st_reg.run & ext_clk_in & ~st_reg.ext_prev;
            CFO_CPS_SYS: tick = st_reg.run;
            default: tick = st_reg.run;
        endcase
    end
    assign do_wr = st_reg.awok & st_reg.wok & ~st_reg.bvalid;
    // byte writes to capture pairs go straight to the modules
    always_comb
    begin
        for (int i = 0; i < CFO_NMOD; i++)
        begin
            wr_lo[i] = do_wr & (st_reg.awaddr == CFO_ADDR_CAP0 + 8'(i * CFO_MOD_STRIDE)) & st_reg.wstrb[0];
            wr_hi[i] = do_wr & (st_reg.awaddr == CFO_ADDR_CAP0 + 8'(i * CFO_MOD_STRIDE)) & st_reg.wstrb[1];
        end
    end
    genvar g;
    generate
        for (g = 0; g < CFO_NMOD; g++)
        begin : gm
            cfo_module u_mod (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(tick),
                .count(st_reg.count),
                .mode(st_reg.mmode[g]),
                .len_sel(st_reg.len),
                .pin_in(pin_in[g]),
                .wr_low(wr_lo[g]),
                .wr_high(wr_hi[g]),
                .wdata(st_reg.wdata[15:0]),
                .cap(cap[g]),
                .pin_out(mout[g]),
                .event_hit(hit[g])
            );
        end
    endgenerate
    // main state: counter, registers, bus handshakes
    always_comb
    begin
        st_next = st_reg;
        st_next.ext_prev = ext_clk_in;
        st_next.div = (st_reg.div == CFO_DIV12 || tick) ? 4'h0 : st_reg.div + 4'h1;
        if (tick)
            st_next.count = st_reg.count + 16'h0001;
        // accept address and data in either order
        if (s_awvalid & ~st_reg.awok)
        begin
            st_next.awok = 1'b1;
            st_next.awaddr = s_awaddr;
        end
        if (s_wvalid & ~st_reg.wok)
        begin
            st_next.wok = 1'b1;
            st_next.wdata = s_wdata;
            st_next.wstrb = s_wstrb;
        end
        // flag clear by write-one goes first so a same-cycle hit wins
        if (do_wr)
        begin
            st_next.awok = 1'b0;
            st_next.wok = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = CFO_RESP_OKAY;
            case (st_reg.awaddr)
                CFO_ADDR_CTRL:
                begin
                    if (st_reg.wstrb[0])
                    begin
                        st_next.flags = st_reg.flags & ~st_reg.wdata[CFO_NMOD-1:0];
                        st_next.run = st_reg.wdata[CFO_RUN_BIT];
                    end
                end
                CFO_ADDR_MODE:
                begin
                    if (st_reg.wstrb[0])
                        st_next.cps = st_reg.wdata[CFO_CPS_LSB +: 3];
                    if (st_reg.wstrb[1])
                        st_next.len = st_reg.wdata[CFO_LEN_LSB +: 2];
                end
                CFO_ADDR_CNT:
                begin
                    if (st_reg.wstrb[0])
                        st_next.count[7:0] = st_reg.wdata[7:0];
                    if (st_reg.wstrb[1])
                        st_next.count[15:8] = st_reg.wdata[15:8];
                end
                CFO_ADDR_PIN:
                begin
                    if (st_reg.wstrb[0])
                        st_next.oe = st_reg.wdata[CFO_NMOD-1:0];
                end
                CFO_ADDR_IMASK:
                begin
                    if (st_reg.wstrb[0])
                        st_next.imask = st_reg.wdata[CFO_NMOD-1:0];
                end
                default:
                begin
                    st_next.bresp = CFO_RESP_SLVERR;
                    for (int i = 0; i < CFO_NMOD; i++)
                    begin
                        if (st_reg.awaddr == CFO_ADDR_MMODE0 + 8'(i * CFO_MOD_STRIDE))
                        begin
                            st_next.bresp = CFO_RESP_OKAY;
                            if (st_reg.wstrb[0])
                                st_next.mmode[i] = st_reg.wdata[7:0];
                        end
                        if (st_reg.awaddr == CFO_ADDR_CAP0 + 8'(i * CFO_MOD_STRIDE))
                            st_next.bresp = CFO_RESP_OKAY;
                    end
                end
            endcase
        end
        st_next.flags = st_next.flags | hit;
        if (st_reg.bvalid & s_bready)
            st_next.bvalid = 1'b0;
        // read path, one read at a time
        if (s_arvalid & ~st_reg.rvalid)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp = CFO_RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            case (s_araddr)
                CFO_ADDR_CTRL: st_next.rdata = 32'({st_reg.run, 2'h0, st_reg.flags});
                CFO_ADDR_MODE: st_next.rdata = 32'({st_reg.len, 4'h0, st_reg.cps, 1'b0});
                CFO_ADDR_CNT: st_next.rdata = 32'(st_reg.count);
                CFO_ADDR_PIN: st_next.rdata = 32'({pin_in, 4'h0, st_reg.oe});
                CFO_ADDR_IMASK: st_next.rdata = 32'(st_reg.imask);
                default:
                begin
                    st_next.rresp = CFO_RESP_SLVERR;
                    for (int i = 0; i < CFO_NMOD; i++)
                    begin
                        if (s_araddr == CFO_ADDR_MMODE0 + 8'(i * CFO_MOD_STRIDE))
                        begin
                            st_next.rresp = CFO_RESP_OKAY;
                            st_next.rdata = 32'(st_reg.mmode[i]);
                        end
                        if (s_araddr == CFO_ADDR_CAP0 + 8'(i * CFO_MOD_STRIDE))
                        begin
                            st_next.rresp = CFO_RESP_OKAY;
                            st_next.rdata = 32'(cap[i]);
                        end
                    end
                end
            endcase
        end
        else if (st_reg.rvalid & s_rready)
            st_next.rvalid = 1'b0;
        st_next.pout = mout;
        st_next.irq = |(st_reg.flags & st_reg.imask);
        if (~aresetn)
            st_next = '0;
    end
    always_ff @(posedge aclk)
        st_reg <= st_next;
    assign s_awready = ~st_reg.awok;
    assign s_wready = ~st_reg.wok;
    assign s_bvalid = st_reg.bvalid;
    assign s_bresp = st_reg.bresp;
    assign s_arready = ~st_reg.rvalid;
    assign s_rvalid = st_reg.rvalid;
    assign s_rdata = st_reg.rdata;
    assign s_rresp = st_reg.rresp;
    assign pin_out = st_reg.pout;
    assign pin_oe = st_reg.oe;
    assign irq = st_reg.irq;
    // a hit always lands in the flag, even against a clear
    flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        hit[0] |=> st_reg.flags[0])
        else $error("match flag not set after hit");
    // flag holds unless software writes the control register
    flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg.flags[0] && !(do_wr && st_reg.awaddr == CFO_ADDR_CTRL) |=> st_reg.flags[0])
        else $error("match flag cleared without software");
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(st_reg.flags & st_reg.imask)) |=> irq)
        else $error("irq missing for enabled flag");
    count_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && !do_wr |=> st_reg.count == 16'($past(st_reg.count) + 16'h0001))
        else $error("counter did not step on array tick");
    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");
endmodule
`default_nettype wire

//--- tb/cfo_pins_model.sv
// external pin sources and count clock facing the counter array
`timescale 1ns/10ps
`default_nettype none
module cfo_pins_model
    import cfo_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic [CFO_NMOD-1:0] src, // external source levels
    input wire logic [CFO_NMOD-1:0] pin_out, // device drive levels
    input wire logic [CFO_NMOD-1:0] pin_oe, // device drive enables
    output logic [CFO_NMOD-1:0] pin_in, // resolved pin levels
    output var logic ext_clk // external count source
);
    // a driven pin shows the device level, otherwise the outside source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & src);
    initial ext_clk = 1'b0;
    // count source stands low between bursts; each level lasts three clocks
    task automatic ext_pulses(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            ext_clk <= 1'b1;
            repeat (3) @(posedge aclk);
            ext_clk <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask
endmodule
`default_nettype wire

//--- tb/capture_freq_out_array_tb.sv
// self-checking bench for the counter array capture and frequency output
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
        err_total++; \
        $display("wrong value %s expected %0h seen %0h", nm, e, g); \
    end \
end
module capture_freq_out_array_tb import cfo_pkg::*;;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0;
    logic [31:0] s_wdata = 32'h0, s_rdata, rv, c;
    logic [3:0] s_wstrb = 4'hf;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ext_clk_in, irq;
    logic [1:0] s_bresp, s_rresp, rsp;
    logic [CFO_NMOD-1:0] pin_in, pin_out, pin_oe, src = 4'h0;
    int err_total = 0, check_count = 0, g;
    typedef struct {logic [7:0] mode; logic lvl; logic flag;} cfo_row_s;
    // edge select rows on module 0: mode, new pin level, expected flag
    cfo_row_s rows [7] = '{'{8'h20, 1'b1, 1'b1}, '{8'h20, 1'b0, 1'b0}, '{8'h10, 1'b1, 1'b0},
        '{8'h10, 1'b0, 1'b1}, '{8'h30, 1'b1, 1'b1}, '{8'h30, 1'b0, 1'b1}, '{8'h00, 1'b1, 1'b0}};
    int hv [4] = '{5, 1, 0, 0};
    int gv [4] = '{5, 1, 256, 0};

    cfo_top dut
    (
        .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .ext_clk_in(ext_clk_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq)
    );
    cfo_pins_model pins
    (
        .aclk(aclk), .src(src), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .ext_clk(ext_clk_in)
    );

    // 125 MHz system clock
    always #4 aclk = ~aclk;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_awready)
                s_awvalid <= 1'b0;
            if (s_wready)
                s_wvalid <= 1'b0;
            if (s_bvalid)
                break;
        end
        s_bready <= 1'b0;
        rsp = s_bresp;
        if (n == 50)
        begin
            err_total++;
            stop_test;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_arready)
                s_arvalid <= 1'b0;
            if (s_rvalid)
                break;
        end
        s_rready <= 1'b0;
        rv = s_rdata;
        rsp = s_rresp;
        if (n == 50)
        begin
            err_total++;
            stop_test;
        end
    endtask

    // cycles between two toggles of module 2's output, zero if none comes
    task automatic gap(output int cyc);
        int n;
        logic p;
        cyc = 0;
        p = pin_out[2];
        for (n = 0; n < 600 && pin_out[2] === p; n++)
            @(posedge aclk);
        if (n < 600)
        begin
            p = pin_out[2];
            for (n = 0; n < 600 && pin_out[2] === p; n++)
                @(posedge aclk);
            cyc = n;
        end
    endtask

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK("irq_reset", 1'b0, irq)
        `CHK("pin_reset", 4'h0, pin_out)
        rd(8'h40);
        `CHK("rd_unmapped", CFO_RESP_SLVERR, rsp)
        `CHK("rd_unmapped_data", 32'h0, rv)
        wr(8'h44, 32'h0);
        `CHK("wr_unmapped", CFO_RESP_SLVERR, rsp)
        // pin levels held six clocks, above the two-clock minimum
        for (int i = 0; i < 7; i++)
        begin
            wr(CFO_ADDR_MMODE0, {24'h0, rows[i].mode});
            wr(CFO_ADDR_CTRL, 32'h0f);
            src[0] <= rows[i].lvl;
            repeat (6) @(posedge aclk);
            rd(CFO_ADDR_CTRL);
            `CHK("edge_flag", rows[i].flag, rv[0])
            rd(CFO_ADDR_PIN);
            `CHK("pin_level", rows[i].lvl, rv[8])
        end
        // stop the counter so the captured value is known exactly
        wr(CFO_ADDR_MODE, 32'(CFO_CPS_SYS) << CFO_CPS_LSB);
        wr(CFO_ADDR_CTRL, 32'h4f);
        repeat (20) @(posedge aclk);
        wr(CFO_ADDR_CTRL, 32'h0f);
        rd(CFO_ADDR_CNT);
        c = rv;
        `CHK("count_moves", 1'b1, c[15:0] != 16'h0)
        wr(CFO_ADDR_MMODE0 + 8'h04, 32'h20);
        src[1] <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(CFO_ADDR_CAP0 + 8'h04);
        `CHK("capture", c[15:0], rv[15:0])
        rd(CFO_ADDR_CTRL);
        `CHK("cap_flag", 1'b1, rv[1])
        // interrupt raised, kept, masked, then cleared by software
        wr(CFO_ADDR_IMASK, 32'h2);
        repeat (3) @(posedge aclk);
        `CHK("irq_on", 1'b1, irq)
        repeat (20) @(posedge aclk);
        rd(CFO_ADDR_CTRL);
        `CHK("flag_kept", 1'b1, rv[1])
        wr(CFO_ADDR_IMASK, 32'h0);
        repeat (3) @(posedge aclk);
        `CHK("irq_masked", 1'b0, irq)
        wr(CFO_ADDR_IMASK, 32'h2);
        wr(CFO_ADDR_CTRL, 32'h02);
        repeat (3) @(posedge aclk);
        `CHK("irq_cleared", 1'b0, irq)
        rd(CFO_ADDR_CTRL);
        `CHK("flag_cleared", 1'b0, rv[1])
        // external source: exactly one count per rising edge
        wr(CFO_ADDR_MODE, 32'(CFO_CPS_EXT) << CFO_CPS_LSB);
        wr(CFO_ADDR_CTRL, 32'h40);
        rd(CFO_ADDR_CNT);
        c = rv;
        pins.ext_pulses(5);
        repeat (4) @(posedge aclk);
        rd(CFO_ADDR_CNT);
        `CHK("ext_count", c[15:0] + 16'h5, rv[15:0])
        // square wave on module 2 with the counter on the system clock
        wr(CFO_ADDR_MODE, (32'h2 << CFO_LEN_LSB) | (32'(CFO_CPS_SYS) << CFO_CPS_LSB));
        rd(CFO_ADDR_MODE);
        `CHK("len_read", 2'h2, rv[9:8])
        `CHK("cps_read", CFO_CPS_SYS, rv[3:1])
        for (int i = 0; i < 4; i++)
        begin
            wr(CFO_ADDR_CAP0 + 8'h08, 32'(hv[i]) << 8);
            wr(CFO_ADDR_MMODE0 + 8'h08, (i < 3) ? 32'h46 : 32'h06);
            repeat (2) @(posedge aclk);
            gap(g);
            `CHK("toggle_gap", gv[i], g)
        end
        // drive enable of module 2 comes from the pin register
        wr(CFO_ADDR_PIN, 32'h4);
        repeat (2) @(posedge aclk);
        `CHK("pin_oe", 4'h4, pin_oe)
        stop_test;
    end
endmodule
`default_nettype wire
